// ==== logic/pil_pkg.sv ====
// Package for the injection symbol and line-state register bank.
// Assumes an APB master with 32-bit data and one clock, pclk.
`default_nettype none
package pil_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [7:0] IDX_THRESHOLD = 8'h05;  // Injection threshold
  localparam logic [7:0] IDX_SYM_LOWER = 8'h06;  // Injection symbol, bits 0..4
  localparam logic [7:0] IDX_SYM_UPPER = 8'h07;  // Injection symbol, bits 5..9
  localparam logic [7:0] IDX_LINE_STAT = 8'h08;  // Current receive state status
  localparam logic [7:0] IDX_INJ_CTRL  = 8'h09;  // Injection mode and status
  localparam int         ADDR_LSB      = 2;      // Word aligned registers

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int         SYM_FIELD_W   = 5;      // Symbol bits per register
  localparam int         PAIR_W        = 10;     // One 5B symbol pair
  localparam int         LS_CODE_W     = 3;      // Line state code width
  localparam int         LS_UNK_BIT    = 3;      // Unknown line state flag
  localparam logic [7:0] SYM_RST       = 8'he0;  // Reserved bits set to 1
  localparam logic [7:0] THR_RST       = 8'h00;  // Threshold after reset
  localparam logic [3:0] LS_RST        = 4'h8;   // Unknown flag set, code 0
  localparam int         CTRL_DONE_BIT = 2;      // One-shot done, read only
  localparam int         CTRL_ARM_BIT  = 3;      // One-shot armed, read only

  // ************************************************************
  // Injection modes
  // ************************************************************
  typedef enum logic [1:0] {
    PIL_MODE_OFF  = 2'h0,
    PIL_MODE_ONCE = 2'h1,
    PIL_MODE_PER  = 2'h2,
    PIL_MODE_CONT = 2'h3
  } pil_mode_e;

  // One received or transmitted symbol pair
  typedef struct packed {
    logic              valid;  // Pair present this cycle
    logic              data;   // Pair is a data pair
    logic              jk;     // Pair is the JK starting delimiter
    logic [PAIR_W-1:0] pair;   // Symbols in 5B code
  } pil_pair_s;

  // Line state report from the receiver
  typedef struct packed {
    logic                 change;   // New line state recognized
    logic                 unknown;  // New state is unknown
    logic [LS_CODE_W-1:0] code;     // Code of the new state
  } pil_ls_s;

endpackage
`default_nettype wire

// ==== logic/pil_injector.sv ====
// Symbol pair injector: replaces received data pairs by the programmed pair.
// Assumes the receiver delivers at most one pair per clock, synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module pil_injector (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire pil_pkg::pil_mode_e            mode,        // Active mode
  input  wire logic                          arm,         // One-shot arm pulse
  input  wire logic [7:0]                    threshold,   // Count n
  input  wire logic [pil_pkg::PAIR_W-1:0]    inj_pair,    // Programmed pair
  input  wire pil_pkg::pil_pair_s            rx_in,       // Received pairs
  output pil_pkg::pil_pair_s                 tx_out,      // Pairs after injection
  output logic                               armed,       // One-shot waiting
  output logic                               done         // One-shot fired
);

  // ************************************************************
  // One-shot sequencer
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_COUNT = 2'b11,
    ST_FIRED = 2'b10
  } pil_inj_e;

  pil_inj_e   state_ff;   // One-shot state
  logic [7:0] cnt_ff;     // Byte positions seen since JK, or pairs in period
  logic       hit;        // Replace the current pair

  // Counts data pairs behind the JK and fires once at position n
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
    end else if (arm) begin
      state_ff <= ST_WAIT;
    end else if (mode != pil_pkg::PIL_MODE_ONCE) begin
      state_ff <= ST_IDLE;
    end else if (rx_in.valid) begin
      unique case (state_ff)
        ST_WAIT: begin
          if (rx_in.jk) state_ff <= ST_COUNT;
        end
        ST_COUNT: begin
          if (hit) state_ff <= ST_FIRED;
        end
        ST_IDLE, ST_FIRED: begin
          state_ff <= state_ff;
        end
      endcase
    end
  end

  // Shared counter: position after JK in one-shot, period in periodic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 8'h00;
    end else if (arm || mode == pil_pkg::PIL_MODE_OFF) begin
      cnt_ff <= 8'h00;
    end else if (rx_in.valid) begin
      if (rx_in.jk && state_ff == ST_WAIT) begin
        cnt_ff <= 8'h00;
      end else if (mode == pil_pkg::PIL_MODE_PER && hit) begin
        cnt_ff <= 8'h00;                           // Restart the period
      end else if (rx_in.data && cnt_ff != 8'hff) begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end

  // Decide whether this pair is replaced
  always_comb begin
    hit = 1'b0;
    if (rx_in.valid && rx_in.data) begin
      unique case (mode)
        pil_pkg::PIL_MODE_ONCE: hit = (state_ff == ST_COUNT) && (cnt_ff == threshold);
        // A threshold of 0 or 1 means every data pair in periodic mode
        pil_pkg::PIL_MODE_PER:  hit = (cnt_ff + 8'h01 >= threshold);
        pil_pkg::PIL_MODE_CONT: hit = 1'b1;
        pil_pkg::PIL_MODE_OFF:  hit = 1'b0;
      endcase
    end
  end

  // Registered output stage, one cycle of latency for every pair
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out <= '0;
    end else begin
      tx_out      <= rx_in;
      if (hit) tx_out.pair <= inj_pair;
    end
  end

  // Visible one-shot status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
      done  <= 1'b0;
    end else begin
      armed <= arm || ((state_ff == ST_WAIT || state_ff == ST_COUNT) && !(hit && state_ff == ST_COUNT)
               && mode == pil_pkg::PIL_MODE_ONCE);
      done  <= !arm && (state_ff == ST_FIRED || (state_ff == ST_COUNT && hit))
               && mode == pil_pkg::PIL_MODE_ONCE;
    end
  end

endmodule
`default_nettype wire

// ==== logic/pil_regs.sv ====
// Register bank for symbol injection and receive line state, APB slave.
// Assumes a single 50 MHz pclk; receiver and data path are on the same clock.
//
// Notes on behaviour
// - Lower and upper registers hold injected pair
// - One-shot: inject n bytes after next JK
// - Periodic: inject every nth symbol pair
// - Continuous: replace every data symbol
// - Upper symbol register at 07h, always RW
// - Upper bits D0..D4 carry symbol bits 5..9
// - Reserved upper bits D5..D7 reset to 1
// - Reserved bit writes change no behaviour
// - Status always shows current detected line state
// - New state clears old bits, sets new
// - Reset forces unknown line state flag
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module pil_regs (
  input  wire logic                pclk,        // 50 MHz clock
  input  wire logic                presetn,     // Asynchronous reset, active low
  input  wire logic                psel,        // APB select
  input  wire logic                penable,     // APB access phase
  input  wire logic                pwrite,      // APB direction
  input  wire logic [11:0]         paddr,       // APB byte address
  input  wire logic [31:0]         pwdata,      // APB write data
  output logic      [31:0]         prdata,      // APB read data
  output logic                     pready,      // APB ready
  output logic                     pslverr,     // APB error, unmapped address
  input  wire pil_pkg::pil_pair_s  rx_pair,     // Received pair stream
  input  wire pil_pkg::pil_ls_s    rx_ls,       // Line state reports
  output pil_pkg::pil_pair_s       tx_pair      // Pair stream after injection
);

  // ************************************************************
  // Register state
  // ************************************************************
  logic [7:0]                 thr_ff;      // Injection threshold n
  logic [7:0]                 sym_lo_ff;   // Injection symbol, lower half
  logic [7:0]                 sym_hi_ff;   // Injection symbol, upper half
  logic [3:0]                 ls_ff;       // Unknown flag and state code
  pil_pkg::pil_mode_e         mode_ff;     // Injection mode
  logic                       arm_ff;      // One-shot arm pulse
  logic                       armed;       // One-shot waiting for its slot
  logic                       done;        // One-shot already fired

  // ************************************************************
  // APB decode
  // ************************************************************
  logic [7:0]                 idx;         // Word index of the access
  logic                       setup;       // Setup phase of a new transfer
  logic                       wr_go;       // Write takes effect this edge
  logic                       mapped;      // Index hits a register
  logic [7:0]                 rd_val;      // Read mux result
  logic [pil_pkg::PAIR_W-1:0] inj_pair;    // Pair handed to the injector

  assign idx    = paddr[pil_pkg::ADDR_LSB +: 8];
  assign setup  = psel && !penable;
  // Write lands only at the edge the master sees pready high
  assign wr_go  = psel && penable && pready && pwrite;
  assign mapped = (idx == pil_pkg::IDX_THRESHOLD) || (idx == pil_pkg::IDX_SYM_LOWER) ||
                  (idx == pil_pkg::IDX_SYM_UPPER) || (idx == pil_pkg::IDX_LINE_STAT) ||
                  (idx == pil_pkg::IDX_INJ_CTRL);

  // Read mux; nothing here has a read side effect
  always_comb begin
    rd_val = 8'h00;
    unique case (idx)
      pil_pkg::IDX_THRESHOLD: rd_val = thr_ff;
      pil_pkg::IDX_SYM_LOWER: rd_val = sym_lo_ff;
      pil_pkg::IDX_SYM_UPPER: rd_val = sym_hi_ff;
      pil_pkg::IDX_LINE_STAT: rd_val = {4'h0, ls_ff};
      pil_pkg::IDX_INJ_CTRL: begin
        rd_val                        = {6'h00, mode_ff};
        rd_val[pil_pkg::CTRL_DONE_BIT] = done;
        rd_val[pil_pkg::CTRL_ARM_BIT]  = armed;
      end
      default: rd_val = 8'h00;
    endcase
  end

  // ************************************************************
  // APB answer: no wait state, pready in the first access cycle
  // ************************************************************
  // Answer is prepared in setup so every output leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_val};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // ************************************************************
  // Writable registers
  // ************************************************************
  // Threshold register, read and write at any time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thr_ff <= pil_pkg::THR_RST;
    end else if (wr_go && idx == pil_pkg::IDX_THRESHOLD) begin
      thr_ff <= pwdata[7:0];
    end
  end

  // Lower symbol register; reserved bits stored but never used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_lo_ff <= pil_pkg::SYM_RST;
    end else if (wr_go && idx == pil_pkg::IDX_SYM_LOWER) begin
      sym_lo_ff <= pwdata[7:0];
    end
  end

  // Upper symbol register, no access restriction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sym_hi_ff <= pil_pkg::SYM_RST;
    end else if (wr_go && idx == pil_pkg::IDX_SYM_UPPER) begin
      sym_hi_ff <= pwdata[7:0];
    end
  end

  // Only the low five bits of each half form the pair; D5..D7 are dropped
  // here so a reserved bit can never reach the line
  assign inj_pair = {sym_hi_ff[pil_pkg::SYM_FIELD_W-1:0],
                     sym_lo_ff[pil_pkg::SYM_FIELD_W-1:0]};

  // Injection mode; writing one-shot mode (re)arms the sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff <= pil_pkg::PIL_MODE_OFF;
      arm_ff  <= 1'b0;
    end else begin
      arm_ff <= 1'b0;
      if (wr_go && idx == pil_pkg::IDX_INJ_CTRL) begin
        mode_ff <= pil_pkg::pil_mode_e'(pwdata[1:0]);
        arm_ff  <= (pwdata[1:0] == pil_pkg::PIL_MODE_ONCE);
      end
    end
  end

  // ************************************************************
  // Line state status
  // ************************************************************
  // Each new report replaces the whole field, so old bits clear and new
  // bits set in one edge; host writes never reach it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_ff <= pil_pkg::LS_RST;
    end else if (rx_ls.change) begin
      ls_ff[pil_pkg::LS_UNK_BIT]          <= rx_ls.unknown;
      ls_ff[pil_pkg::LS_CODE_W-1:0]       <= rx_ls.unknown ? 3'h0 : rx_ls.code;
    end
  end

  // ************************************************************
  // Injection data path
  // ************************************************************
  pil_injector u_injector (
    .pclk      (pclk),
    .presetn   (presetn),
    .mode      (mode_ff),
    .arm       (arm_ff),
    .threshold (thr_ff),
    .inj_pair  (inj_pair),
    .rx_in     (rx_pair),
    .tx_out    (tx_pair),
    .armed     (armed),
    .done      (done)
  );

endmodule
`default_nettype wire

// ==== bench/pil_regs_chk.sv ====
// Port checker for the injection and line-state register bank.
// Assumes a bind to pil_regs; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pil_regs_chk (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire pil_pkg::pil_pair_s rx_pair,
  input wire pil_pkg::pil_pair_s tx_pair
);
  // *****
  // Bus and data path relations
  // *****
  wire logic [7:0] idx    = paddr[9:2];                   // Word index
  wire logic       setup  = psel && !penable;             // Setup cycle
  wire logic       mapped = idx >= 8'h05 && idx <= 8'h09; // Decoded range
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_next; setup |=> pready; endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_cause; pready |-> $past(setup); endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
  property p_ready_once; setup ##1 pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");
  property p_err_bad; setup && !mapped |=> pslverr && prdata == 32'h0; endproperty
  a_err_bad: assert property (p_err_bad) else $error("unmapped not refused");
  property p_ok_mapped; setup && mapped |=> !pslverr; endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("mapped access refused");
  property p_byte; pready |-> prdata[31:8] == 24'h0; endproperty
  a_byte: assert property (p_byte) else $error("upper read bits set");
  property p_stat; setup && !pwrite && idx == 8'h08 |=> prdata[7:4] == 4'h0 &&
    (!prdata[3] || prdata[2:0] == 3'h0); endproperty
  a_stat: assert property (p_stat) else $error("bad status shape");
  property p_pass; rx_pair.valid && !rx_pair.data |=> tx_pair == $past(rx_pair); endproperty
  a_pass: assert property (p_pass) else $error("control pair altered");
  property p_follow; 1'b1 |=> tx_pair.valid == $past(rx_pair.valid); endproperty
  a_follow: assert property (p_follow) else $error("pair valid lost");
endmodule
bind pil_regs pil_regs_chk i_pil_regs_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rx_pair(rx_pair), .tx_pair(tx_pair));
`default_nettype wire

// ==== bench/pil_host_model.sv ====
// Host model on the management port: an APB master.
// Assumes the slave raises pready; flags hung when it never does.
`timescale 1ns/1ps
`default_nettype none
module pil_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  output logic             hung
);
  // Idle bus at time zero
  initial {psel, penable, pwrite, paddr, pwdata, hung} = '0;
  // One transfer; request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!pready && n < 50);
    hung    <= !pready;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines show no stale value
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== bench/pil_regs_tb.sv ====
// Self-checking bench for the injection and line-state register bank.
// Assumes pil_host_model drives APB; results are checked from queues.
`timescale 1ns/1ps
`default_nettype none
module pil_regs_tb;
  // *****
  // Signals and instances
  // *****
  localparam logic [11:0] A_THR = {2'h0, pil_pkg::IDX_THRESHOLD, 2'h0};
  localparam logic [11:0] A_LO  = {2'h0, pil_pkg::IDX_SYM_LOWER, 2'h0};
  localparam logic [11:0] A_UP  = {2'h0, pil_pkg::IDX_SYM_UPPER, 2'h0};
  localparam logic [11:0] A_LS  = {2'h0, pil_pkg::IDX_LINE_STAT, 2'h0};
  localparam logic [11:0] A_CTL = {2'h0, pil_pkg::IDX_INJ_CTRL, 2'h0};
  logic               pclk = 1'b0;               // 50 MHz clock
  logic               presetn = 1'b0;            // Reset, active low
  logic               psel, penable, pwrite, pready, pslverr, hung;
  logic [11:0]        paddr;                     // Byte address
  logic [31:0]        pwdata, prdata;            // Bus data
  pil_pkg::pil_pair_s rx_pair = '0, tx_pair, t;  // Pair streams
  pil_pkg::pil_ls_s   rx_ls = '0;                // Line state reports
  int                 mismatches = 0;
  int                 comparisons = 0;
  integer             seed = 32'h6050a5d4;
  logic [33:0]        rq[$], e;                  // Notes: read flag, error, data
  pil_pkg::pil_pair_s tq[$];                     // Pairs expected out
  logic [7:0]         up, lo;                    // Programmed symbol halves
  logic [9:0]         rep;                       // Expected replacement
  initial forever #10 pclk = ~pclk;
  pil_regs i_pil_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pair(rx_pair), .rx_ls(rx_ls), .tx_pair(tx_pair));
  pil_host_model i_pil_host_model (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));
  // *****
  // Tasks and monitors
  // *****
  task automatic chk(input string what, input logic [31:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] v, input logic err = 1'b0);
    rq.push_back({1'b1, err, 24'h0, v});
    i_pil_host_model.xfer(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    rq.push_back(34'h0);
    i_pil_host_model.xfer(1'b1, a, {24'h0, v});
  endtask
  // One pair for one cycle; the expectation is noted first
  task automatic send(input logic d, j, input logic [9:0] v, input logic hit);
    tq.push_back({1'b1, d, j, hit ? rep : v});
    @(posedge pclk);
    rx_pair <= {1'b1, d, j, v};
    @(posedge pclk);
    rx_pair <= '0;
  endtask
  task automatic ls(input logic u, input logic [2:0] c);
    @(posedge pclk);
    rx_ls <= {1'b1, u, c};
    @(posedge pclk);
    rx_ls <= '0;
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Each bus answer against the oldest note
  // An unknown ready is treated as an answer so it cannot slip by unchecked
  always @(posedge pclk) if (pready !== 1'b0) begin
    e = rq.pop_front();
    chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
    if (e[33]) chk("prdata", e[31:0], prdata);
  end
  // Each output pair against the oldest note
  always @(posedge pclk) if (tx_pair.valid !== 1'b0) begin
    t = tq.pop_front();
    chk("tx_pair", {19'h0, t}, {19'h0, tx_pair});
  end
  // A bus wait that ran out ends the run
  always @(posedge hung) begin
    mismatches++;
    summarize();
  end
  // *****
  // Scenarios
  // *****
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_UP, 8'he0);
    rd(A_LS, 8'h08);
    rd(12'h028, 8'h00, 1'b1);
    $display("done reset values");
    up = 8'($random(seed));
    lo = 8'h35;
    rep = {up[4:0], lo[4:0]};
    wr(A_UP, up);
    rd(A_UP, up);
    wr(A_LO, lo);
    wr(A_THR, 8'h03);
    wr(A_CTL, 8'h02);
    for (int i = 1; i <= 6; i++) send(1'b1, 1'b0, 10'($random(seed)), i % 3 == 0);
    $display("done periodic");
    wr(A_THR, 8'h02);
    wr(A_CTL, 8'h01);
    send(1'b1, 1'b0, 10'h155, 1'b0);
    send(1'b0, 1'b1, 10'h0c5, 1'b0);
    for (int i = 0; i < 5; i++) send(1'b1, 1'b0, 10'($random(seed)), i == 2);
    rd(A_CTL, 8'h05);
    $display("done one-shot");
    wr(A_UP, up ^ 8'he0);
    wr(A_CTL, 8'h03);
    send(1'b0, 1'b0, 10'($random(seed)), 1'b0);
    for (int i = 0; i < 3; i++) send(1'b1, 1'b0, 10'($random(seed)), 1'b1);
    // Injection off: data pairs must pass untouched
    wr(A_CTL, 8'h00);
    send(1'b1, 1'b0, 10'($random(seed)), 1'b0);
    $display("done continuous");
    ls(1'b0, 3'h2);
    rd(A_LS, 8'h02);
    wr(A_LS, 8'h05);
    rd(A_LS, 8'h02);
    ls(1'b1, 3'h5);
    rd(A_LS, 8'h08);
    $display("done line state");
    repeat (5) @(posedge pclk);
    chk("pending notes", 32'h0, rq.size() + tq.size());
    summarize();
  end
endmodule
`default_nettype wire
